// ### dv/fpuctl_core_model.sv
// Model of the core pipeline and exception entry facing the control block.
`timescale 1ns/1ps
`default_nettype none
module fpuctl_core_model (
   input  wire logic i_core_clk,
   input  wire logic i_fp_stall,
   output logic      o_fp_issue,
   output logic      o_irq_entry,
   output logic      o_irq_return
);
   initial begin
      {o_fp_issue, o_irq_entry, o_irq_return} = 3'h0;
   end
   // Requests follow setup, issue waits out a stall.
   task automatic pulse(input int kind);
      @(negedge i_core_clk);
      while (i_fp_stall !== 1'b0) @(negedge i_core_clk);
      o_fp_issue = (kind == 0);
      o_irq_entry = (kind == 1);
      o_irq_return = (kind == 2);
      @(negedge i_core_clk);
      {o_fp_issue, o_irq_entry, o_irq_return} = 3'h0;
   endtask
endmodule
`default_nettype wire

// ### dv/fpuctl_top_bench.sv
// Testbench for the floating-point context and mode control.
`timescale 1ns/1ps
`default_nettype none
module fpuctl_top_bench
   import fpuctl_pkg::*;
;
   logic       i_core_clk, i_rst_b, i_cfg_we, i_cfg_enable, i_cfg_flush_zero_on;
   logic       i_cfg_half_extended_range_format, i_cfg_nan_canonical_result;
   logic [1:0] i_cfg_ctx, i_cfg_round;
   logic [5:0] i_cfg_exc_en, i_exc_flags;
   wire        i_fp_issue, i_irq_entry, i_irq_return;
   logic       o_enable, o_flush_zero_on, o_half_extended_range_format;
   logic       o_nan_canonical_result, o_fp_exec, o_fp_stall, o_no_coprocessor_fault;
   logic       o_entry_done, o_return_done, o_ctx_wr, o_ctx_rd, o_ctx_saved, o_exc_irq;
   logic [1:0] o_ctx, o_round;
   logic [5:0] o_exc_en;
   logic [4:0] o_frame_words;
   logic [3:0] o_ctx_reg;
   logic [13:0] v;
   int         bad_count = 0, tests_run = 0, hit, nwr, nrd;
   wire [13:0] rb = {o_enable, o_ctx, o_exc_en, o_flush_zero_on,
                     o_half_extended_range_format, o_nan_canonical_result, o_round};
   fpuctl_top DUT (.i_core_clk, .i_rst_b, .i_cfg_we, .i_cfg_enable, .i_cfg_ctx, .i_cfg_exc_en,
      .i_cfg_flush_zero_on, .i_cfg_half_extended_range_format, .i_cfg_nan_canonical_result,
      .i_cfg_round, .i_fp_issue, .i_irq_entry, .i_irq_return, .i_exc_flags, .o_enable, .o_ctx,
      .o_exc_en, .o_flush_zero_on, .o_half_extended_range_format, .o_nan_canonical_result,
      .o_round, .o_fp_exec, .o_fp_stall, .o_no_coprocessor_fault, .o_frame_words,
      .o_entry_done, .o_return_done, .o_ctx_wr, .o_ctx_rd, .o_ctx_reg, .o_ctx_saved, .o_exc_irq);
   fpuctl_core_model core (.i_core_clk, .i_fp_stall(o_fp_stall), .o_fp_issue(i_fp_issue),
      .o_irq_entry(i_irq_entry), .o_irq_return(i_irq_return));
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic put(input logic [13:0] c);
      i_cfg_enable                     = c[13];
      i_cfg_ctx                        = c[12:11];
      i_cfg_exc_en                     = c[10:5];
      i_cfg_flush_zero_on              = c[4];
      i_cfg_half_extended_range_format = c[3];
      i_cfg_nan_canonical_result       = c[2];
      i_cfg_round                      = c[1:0];
   endtask
   task automatic cfg(input logic [13:0] c);
      @(negedge i_core_clk);
      put(c);
      i_cfg_we = 1'b1;
      @(negedge i_core_clk);
      i_cfg_we = 1'b0;
   endtask
   // Follows register moves in index order until the selected completion pulse.
   task automatic watch(input int sel);
      int wi, ri;
      wi = 0;
      ri = 0;
      hit = 0;
      for (int n = 0; n < 40 && hit == 0; n++) begin
         if (wi < 16 && o_ctx_wr === 1'b1 && o_ctx_reg === wi[3:0]) wi++;
         if (ri < 16 && o_ctx_rd === 1'b1 && o_ctx_reg === ri[3:0]) ri++;
         hit = (sel == 0) ? o_fp_exec : (sel == 1) ? o_entry_done : o_return_done;
         if (hit == 0) @(negedge i_core_clk);
      end
      nwr = wi;
      nrd = ri;
   endtask
   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      i_core_clk = 1'b0;
      forever #5 i_core_clk = ~i_core_clk;
   end
   initial begin
      #50000;
      bad_count++;
      end_of_test();
   end
   initial begin
      {i_rst_b, i_cfg_we} = 2'h0;
      i_exc_flags = 6'h00;
      put(14'h0000);
      repeat (2) @(posedge i_core_clk);
      @(negedge i_core_clk);
      i_rst_b = 1'b1;
      chk("defaults", 16'h1000, rb);
      core.pulse(0);
      chk("fault", 16'h0001, {o_fp_exec, o_no_coprocessor_fault});
      for (int r = 0; r < 4; r++) begin
         v = {1'b0, r[1:0], 6'h01 << r, r[0], r[1], ~r[0], r[1:0]};
         cfg(v);
         chk("modes", (r == 3) ? {v[13], 2'b10, v[10:0]} : v, rb);
      end
      for (int p = 0; p < 3; p++) begin
         cfg({1'b1, p[1:0], 11'h000});
         core.pulse(1);
         chk("frame", (p == 0) ? 16'h8 : 16'h1a, o_frame_words);
         watch(1);
         chk("entry_wr", (p == 1) ? 16'h10 : 16'h0, nwr[15:0]);
         core.pulse(0);
         chk("stall", (p == 2) ? 16'h1 : 16'h0, o_fp_stall);
         watch(0);
         chk("save_wr", (p == 2) ? 16'h10 : 16'h0, nwr[15:0]);
         chk("exec", 16'h1, hit[15:0]);
         chk("saved", (p == 0) ? 16'h0 : 16'h1, o_ctx_saved);
         core.pulse(2);
         watch(2);
         chk("reload", (p == 0) ? 16'h0 : 16'h10, nrd[15:0]);
      end
      core.pulse(1);
      watch(1);
      core.pulse(2);
      watch(2);
      chk("no_reload", 16'h0001, {nrd[14:0], hit[0]});
      cfg({1'b0, 2'b10, 6'h05, 5'h00});
      core.pulse(0);
      chk("off_again", 16'h0001, {o_fp_exec, o_no_coprocessor_fault});
      for (int k = 0; k < 6; k++) begin
         cfg({1'b0, 2'b10, 6'h01 << k, 5'h00});
         i_exc_flags = 6'h01 << k;
         @(negedge i_core_clk);
         chk("irq_on", 16'h1, o_exc_irq);
         i_exc_flags = ~(6'h01 << k);
         @(negedge i_core_clk);
         chk("irq_masked", 16'h0, o_exc_irq);
      end
      cfg({1'b1, 2'b01, 6'h3f, 5'h1f});
      core.pulse(1);
      i_rst_b = 1'b0;
      repeat (2) @(posedge i_core_clk);
      @(negedge i_core_clk);
      i_rst_b = 1'b1;
      chk("defaults_again", 16'h1000, rb);
      chk("idle_again", 16'h0008, {o_ctx_wr, o_ctx_saved, o_fp_stall, o_frame_words});
      end_of_test();
   end
endmodule
`default_nettype wire

// ### dv/fpuctl_top_sva.sv
// Checker for the floating-point control block ports.
`timescale 1ns/1ps
`default_nettype none
module fpuctl_top_sva
   import fpuctl_pkg::*;
(
   input wire logic       i_core_clk,
   input wire logic       i_rst_b,
   input wire logic       i_cfg_we,
   input wire logic       i_cfg_enable,
   input wire logic [1:0] i_cfg_round,
   input wire logic       i_fp_issue,
   input wire logic       i_irq_entry,
   input wire logic       i_irq_return,
   input wire logic [5:0] i_exc_flags,
   input wire logic       o_enable,
   input wire logic [1:0] o_ctx,
   input wire logic [5:0] o_exc_en,
   input wire logic [1:0] o_round,
   input wire logic       o_fp_exec,
   input wire logic       o_fp_stall,
   input wire logic       o_no_coprocessor_fault,
   input wire logic [4:0] o_frame_words,
   input wire logic       o_entry_done,
   input wire logic       o_return_done,
   input wire logic       o_ctx_wr,
   input wire logic       o_ctx_rd,
   input wire logic       o_ctx_saved,
   input wire logic       o_exc_irq
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_b);
   a_reset_default: assert property (!$past(i_rst_b) |-> !o_enable && o_ctx == FPUCTL_CTX_LAZY
      && o_round == FPUCTL_ROUND_TO_CLOSEST && o_exc_en == 6'h00) else $error("reset state wrong");
   a_fault_when_off: assert property (i_fp_issue && !o_enable
      |=> o_no_coprocessor_fault && !o_fp_exec) else $error("no fault while off");
   a_exec_needs_on: assert property (o_fp_exec |-> o_enable) else $error("exec while off");
   a_frame_none: assert property (i_irq_entry && o_ctx == FPUCTL_CTX_NONE
      |=> o_frame_words == FPUCTL_FRAME_INT) else $error("frame not eight");
   a_frame_full: assert property (i_irq_entry && o_ctx != FPUCTL_CTX_NONE
      |=> o_frame_words == FPUCTL_FRAME_FULL) else $error("frame not full");
   a_lazy_entry: assert property (i_irq_entry && o_ctx == FPUCTL_CTX_LAZY
      |=> !o_ctx_wr ##1 (!o_ctx_wr && o_entry_done)) else $error("lazy entry wrote");
   a_always_save: assert property (i_irq_entry && o_ctx == FPUCTL_CTX_ALWAYS
      |-> ##[1:3] o_ctx_wr ##[14:22] o_entry_done) else $error("always entry not saved");
   a_stall_save: assert property ($rose(o_fp_stall)
      |-> o_ctx_wr ##[15:20] (o_fp_exec && o_ctx_saved)) else $error("lazy save wrong");
   a_no_exec_stall: assert property (o_fp_stall |-> !o_fp_exec) else $error("exec in stall");
   a_lazy_skip: assert property (i_irq_return && o_ctx == FPUCTL_CTX_LAZY && !o_ctx_saved
      && !i_irq_entry |=> !o_ctx_rd && o_return_done) else $error("needless reload");
   a_exc_irq: assert property (o_exc_irq == |($past(i_exc_flags) & $past(o_exc_en)))
      else $error("exception interrupt wrong");
   a_cfg_load: assert property (i_cfg_we |=> o_round == $past(i_cfg_round)
      && o_enable == $past(i_cfg_enable)) else $error("control not loaded");
endmodule
bind fpuctl_top fpuctl_top_sva u_sva (.i_core_clk, .i_rst_b, .i_cfg_we, .i_cfg_enable,
   .i_cfg_round, .i_fp_issue, .i_irq_entry, .i_irq_return, .i_exc_flags, .o_enable, .o_ctx,
   .o_exc_en, .o_round, .o_fp_exec, .o_fp_stall, .o_no_coprocessor_fault, .o_frame_words,
   .o_entry_done, .o_return_done, .o_ctx_wr, .o_ctx_rd, .o_ctx_saved, .o_exc_irq);
`default_nettype wire

// ### verilog/fpuctl_pkg.sv
// Package with the constants and types of the floating-point context and mode control.
package fpuctl_pkg;

   // ***************************************************************
   // Context policies, modes and frame sizes.
   // ***************************************************************
   typedef enum logic [1:0] {
      FPUCTL_CTX_NONE   = 2'b00,
      FPUCTL_CTX_ALWAYS = 2'b01,
      FPUCTL_CTX_LAZY   = 2'b10
   } fpuctl_ctx_e;

   typedef enum logic [1:0] {
      FPUCTL_ROUND_TO_CLOSEST      = 2'b00,
      FPUCTL_ROUND_UP_POSITIVE     = 2'b01,
      FPUCTL_ROUND_DOWN_NEGATIVE   = 2'b10,
      FPUCTL_ROUND_TRUNCATE        = 2'b11
   } fpuctl_round_e;

   typedef enum logic [2:0] {
      FPUCTL_ST_IDLE    = 3'b000,
      FPUCTL_ST_ENTRY   = 3'b001,
      FPUCTL_ST_HANDLER = 3'b010,
      FPUCTL_ST_SAVE    = 3'b011,
      FPUCTL_ST_RESTORE = 3'b100
   } fpuctl_state_e;

   localparam int          FPUCTL_N_EXC          = 6;
   localparam int          FPUCTL_N_FP_REGS      = 16;
   localparam logic [4:0]  FPUCTL_FRAME_INT      = 5'h08;
   localparam logic [4:0]  FPUCTL_FRAME_FULL     = 5'h1a;
   localparam logic        FPUCTL_RST_ENABLE     = 1'b0;
   localparam fpuctl_ctx_e FPUCTL_RST_CTX        = FPUCTL_CTX_LAZY;
   localparam logic        FPUCTL_RST_FLUSH_ZERO = 1'b0;
   localparam logic        FPUCTL_RST_HALF_ALT   = 1'b0;
   localparam logic        FPUCTL_RST_NAN_CANON  = 1'b0;
   localparam logic [5:0]  FPUCTL_RST_EXC_EN     = 6'h00;
   localparam fpuctl_round_e FPUCTL_RST_ROUND    = FPUCTL_ROUND_TO_CLOSEST;

endpackage

// ### verilog/fpuctl_top.sv
// Floating-point enable, context policy, exception interrupt and mode control.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Unit is disabled after reset and must be enabled before instructions run.
// - Instruction issued while disabled is blocked and raises a no-coprocessor fault.
// - Three context policies on interrupt entry: none, always save, lazy.
// - Policy none gives an eight-word integer-only frame.
// - Policy always stores floating-point context at every interrupt entry.
// - Context policy resets to lazy save and restore.
// - Lazy entry reserves context space but writes only integer state.
// - Lazy: first handler instruction waits until context is stored.
// - Lazy return reloads context only if it was stored.
// - Context is single-precision registers zero through fifteen.
// - Six exception sources raise an interrupt, each individually enabled.
// - Flush-to-zero resets off; when on, near-zero values become zero.
// - Half-precision select chooses standard or extended-range format.
// - Half-precision select resets to the standard format.
// - NaN setting: pass-through by default, or canonical result.
// - Rounding mode: closest by default, up, down or truncate.
// - Stacking floating-point registers grows the frame from 8 to 26 words.
module fpuctl_top
   import fpuctl_pkg::*;
(
   // Clock and reset.
   input  wire logic        i_core_clk,
   input  wire logic        i_rst_b,
   // Control writes from the processor.
   input  wire logic        i_cfg_we,
   input  wire logic        i_cfg_enable,
   input  wire logic [1:0]  i_cfg_ctx,
   input  wire logic [5:0]  i_cfg_exc_en,
   input  wire logic        i_cfg_flush_zero_on,
   input  wire logic        i_cfg_half_extended_range_format,
   input  wire logic        i_cfg_nan_canonical_result,
   input  wire logic [1:0]  i_cfg_round,
   // Pipeline instruction issue.
   input  wire logic        i_fp_issue,
   // Exception entry and return.
   input  wire logic        i_irq_entry,
   input  wire logic        i_irq_return,
   // Exception flags from the datapath.
   input  wire logic [5:0]  i_exc_flags,
   // Control state read back.
   output logic             o_enable,
   output logic [1:0]       o_ctx,
   output logic [5:0]       o_exc_en,
   output logic             o_flush_zero_on,
   output logic             o_half_extended_range_format,
   output logic             o_nan_canonical_result,
   output logic [1:0]       o_round,
   // Instruction control.
   output logic             o_fp_exec,
   output logic             o_fp_stall,
   output logic             o_no_coprocessor_fault,
   // Stacking control.
   output logic [4:0]       o_frame_words,
   output logic             o_entry_done,
   output logic             o_return_done,
   output logic             o_ctx_wr,
   output logic             o_ctx_rd,
   output logic [3:0]       o_ctx_reg,
   output logic             o_ctx_saved,
   // Exception interrupt.
   output logic             o_exc_irq
);

   typedef struct packed {
      logic          enable;
      fpuctl_ctx_e   ctx;
      logic [5:0]    exc_en;
      logic          flush_zero;
      logic          half_alt;
      logic          nan_canon;
      fpuctl_round_e round;
      fpuctl_state_e st;
      logic          saved;
      logic          pend_issue;
      logic          fp_exec;
      logic          fp_stall;
      logic          fault;
      logic [4:0]    frame;
      logic          entry_done;
      logic          return_done;
      logic          ctx_wr;
      logic          ctx_rd;
      logic [3:0]    ctx_reg;
      logic          exc_irq;
   } fpuctl_top_s;

   fpuctl_top_s s_q;
   fpuctl_top_s s_d;
   fpuctl_xfer_if xfer ();

   fpuctl_xfer_seq u_seq (
      .i_core_clk (i_core_clk),
      .i_rst_b    (i_rst_b),
      .xfer       (xfer.seq)
   );

   // ***************************************************************
   // Next-state logic.
   // ***************************************************************
   always_comb begin
      s_d             = s_q;
      s_d.fp_exec     = 1'b0;
      s_d.fault       = 1'b0;
      s_d.entry_done  = 1'b0;
      s_d.return_done = 1'b0;
      xfer.start      = 1'b0;
      xfer.store      = 1'b0;
      if (i_cfg_we) begin
         s_d.enable     = i_cfg_enable;
         s_d.exc_en     = i_cfg_exc_en;
         s_d.flush_zero = i_cfg_flush_zero_on;
         s_d.half_alt   = i_cfg_half_extended_range_format;
         s_d.nan_canon  = i_cfg_nan_canonical_result;
         s_d.round      = fpuctl_round_e'(i_cfg_round);
         if (i_cfg_ctx != 2'b11) begin
            s_d.ctx = fpuctl_ctx_e'(i_cfg_ctx);
         end
      end
      s_d.exc_irq = |(i_exc_flags & s_q.exc_en);
      case (s_q.st)
         FPUCTL_ST_IDLE, FPUCTL_ST_HANDLER: begin
            if (i_irq_entry) begin
               s_d.st    = FPUCTL_ST_ENTRY;
               s_d.saved = 1'b0;
               if (s_q.ctx == FPUCTL_CTX_NONE) begin
                  s_d.frame = FPUCTL_FRAME_INT;
               end else begin
                  s_d.frame = FPUCTL_FRAME_FULL;
               end
               if (s_q.ctx == FPUCTL_CTX_ALWAYS) begin
                  xfer.start = 1'b1;
                  xfer.store = 1'b1;
                  s_d.ctx_wr = 1'b1;
               end
            end else if (s_q.st == FPUCTL_ST_HANDLER && i_irq_return) begin
               if (s_q.saved) begin
                  s_d.st     = FPUCTL_ST_RESTORE;
                  xfer.start = 1'b1;
                  s_d.ctx_rd = 1'b1;
               end else begin
                  s_d.st          = FPUCTL_ST_IDLE;
                  s_d.return_done = 1'b1;
               end
            end else if (i_fp_issue) begin
               if (!s_q.enable) begin
                  s_d.fault = 1'b1;
               end else if (s_q.st == FPUCTL_ST_HANDLER && s_q.ctx == FPUCTL_CTX_LAZY
                            && !s_q.saved) begin
                  s_d.st         = FPUCTL_ST_SAVE;
                  s_d.pend_issue = 1'b1;
                  s_d.fp_stall   = 1'b1;
                  xfer.start     = 1'b1;
                  xfer.store     = 1'b1;
                  s_d.ctx_wr     = 1'b1;
               end else begin
                  s_d.fp_exec = 1'b1;
               end
            end
         end
         FPUCTL_ST_ENTRY: begin
            if (!xfer.busy || xfer.done) begin
               s_d.st         = FPUCTL_ST_HANDLER;
               s_d.entry_done = 1'b1;
               s_d.ctx_wr     = 1'b0;
               s_d.saved      = (s_q.ctx == FPUCTL_CTX_ALWAYS);
            end
         end
         FPUCTL_ST_SAVE: begin
            if (xfer.done) begin
               s_d.st         = FPUCTL_ST_HANDLER;
               s_d.saved      = 1'b1;
               s_d.ctx_wr     = 1'b0;
               s_d.fp_stall   = 1'b0;
               s_d.pend_issue = 1'b0;
               s_d.fp_exec    = 1'b1;
            end
         end
         FPUCTL_ST_RESTORE: begin
            if (xfer.done) begin
               s_d.st          = FPUCTL_ST_IDLE;
               s_d.ctx_rd      = 1'b0;
               s_d.saved       = 1'b0;
               s_d.return_done = 1'b1;
            end
         end
         default: begin
            s_d.st = FPUCTL_ST_IDLE;
         end
      endcase
      s_d.ctx_reg = xfer.reg_vld ? xfer.reg_idx : 4'h0;
   end

   // ***************************************************************
   // State register.
   // ***************************************************************
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         s_q            <= '0;
         s_q.enable     <= FPUCTL_RST_ENABLE;
         s_q.ctx        <= FPUCTL_RST_CTX;
         s_q.exc_en     <= FPUCTL_RST_EXC_EN;
         s_q.flush_zero <= FPUCTL_RST_FLUSH_ZERO;
         s_q.half_alt   <= FPUCTL_RST_HALF_ALT;
         s_q.nan_canon  <= FPUCTL_RST_NAN_CANON;
         s_q.round      <= FPUCTL_RST_ROUND;
         s_q.st         <= FPUCTL_ST_IDLE;
         s_q.frame      <= FPUCTL_FRAME_INT;
      end else begin
         s_q <= s_d;
      end
   end

   // ***************************************************************
   // Outputs.
   // ***************************************************************
   // Mode settings to the datapath, then instruction, stacking and interrupt outputs.
   assign o_enable                     = s_q.enable;
   assign o_ctx                        = s_q.ctx;
   assign o_exc_en                     = s_q.exc_en;
   assign o_flush_zero_on              = s_q.flush_zero;
   assign o_half_extended_range_format = s_q.half_alt;
   assign o_nan_canonical_result       = s_q.nan_canon;
   assign o_round                      = s_q.round;
   assign o_fp_exec                    = s_q.fp_exec;
   assign o_fp_stall                   = s_q.fp_stall;
   assign o_no_coprocessor_fault       = s_q.fault;
   assign o_frame_words                = s_q.frame;
   assign o_entry_done                 = s_q.entry_done;
   assign o_return_done                = s_q.return_done;
   assign o_ctx_wr                     = s_q.ctx_wr;
   assign o_ctx_rd                     = s_q.ctx_rd;
   assign o_ctx_reg                    = s_q.ctx_reg;
   assign o_ctx_saved                  = s_q.saved;
   assign o_exc_irq                    = s_q.exc_irq;

endmodule
`default_nettype wire

// ### verilog/fpuctl_xfer_if.sv
// Interface carrying one register-transfer request between the controller and its sequencer.
`timescale 1ns/1ps
`default_nettype none
interface fpuctl_xfer_if;
   logic       start;
   logic       store;
   logic       busy;
   logic       done;
   logic [3:0] reg_idx;
   logic       reg_vld;

   modport ctrl (output start, output store, input busy, input done,
                 input reg_idx, input reg_vld);
   modport seq  (input start, input store, output busy, output done,
                 output reg_idx, output reg_vld);
endinterface
`default_nettype wire

// ### verilog/fpuctl_xfer_seq.sv
// Sequencer that walks the sixteen single-precision registers for a save or restore.
`timescale 1ns/1ps
`default_nettype none
module fpuctl_xfer_seq
   import fpuctl_pkg::*;
(
   // Clock and reset.
   input  wire logic i_core_clk,
   input  wire logic i_rst_b,
   // Transfer port.
   fpuctl_xfer_if.seq xfer
);

   typedef struct packed {
      logic       busy;
      logic       done;
      logic [3:0] idx;
   } fpuctl_seq_s;

   fpuctl_seq_s s_q;
   fpuctl_seq_s s_d;

   // ***************************************************************
   // Register walk.
   // ***************************************************************
   always_comb begin
      s_d      = s_q;
      s_d.done = 1'b0;
      if (s_q.busy) begin
         if (s_q.idx == 4'(FPUCTL_N_FP_REGS - 1)) begin
            s_d.busy = 1'b0;
            s_d.done = 1'b1;
            s_d.idx  = 4'h0;
         end else begin
            s_d.idx = s_q.idx + 4'h1;
         end
      end else if (xfer.start) begin
         s_d.busy = 1'b1;
         s_d.idx  = 4'h0;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign xfer.busy    = s_q.busy;
   assign xfer.done    = s_q.done;
   assign xfer.reg_idx = s_q.idx;
   assign xfer.reg_vld = s_q.busy;

endmodule
`default_nettype wire
